//--- rtl/lcd_ctrl_host_bus_port.v
`default_nettype none
`include "host_port_consts.vh"
module lcd_ctrl_host_bus_port #(
  parameter DISPLAY_WORDS = `DISPLAY_WORDS,
  parameter REG_WORDS = `REG_WORDS
) (
  input wire ref_clk,
  input wire rst,
  input wire display_input_clk,
  input wire host_bus_clk,
  input wire chip_select_n,
  input wire [15:0] host_addr_in,
  input wire addr_bit_zero,
  input wire [15:0] host_data_in,
  output reg [15:0] host_data_out,
  output wire host_data_oe,
  input wire low_byte_write_strobe_n,
  input wire high_byte_write_strobe_n,
  input wire low_byte_read_strobe_n,
  input wire read_write_n,
  input wire bus_status_n,
  output reg wait_n,
  input wire bus_mode_strap_0,
  input wire bus_mode_strap_1,
  input wire bus_mode_strap_2,
  input wire endian_select_strap,
  input wire refresh_busy,
  input wire [31:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  wire [6:0] pins_s;
  wire [15:0] addr_s;
  wire [15:0] wdata_s;
  sync_two_flop #(.WIDTH(7)) u_sync_ctl (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in({host_bus_clk, chip_select_n, addr_bit_zero, low_byte_write_strobe_n,
      high_byte_write_strobe_n, low_byte_read_strobe_n, read_write_n}),
    .sync_out(pins_s)
  );
  sync_two_flop #(.WIDTH(16)) u_sync_addr (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in(host_addr_in),
    .sync_out(addr_s)
  );
  sync_two_flop #(.WIDTH(16)) u_sync_data (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in(host_data_in),
    .sync_out(wdata_s)
  );
  wire [4:0] strap_s;
  sync_two_flop #(.WIDTH(5)) u_sync_strap (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in({bus_mode_strap_2, bus_mode_strap_1, bus_mode_strap_0, bus_status_n,
      endian_select_strap}),
    .sync_out(strap_s)
  );
  wire bclk_s = pins_s[6];
  wire cs_n_s = pins_s[5];
  wire a0_s = pins_s[4];
  wire we0_n_s = pins_s[3];
  wire we1_n_s = pins_s[2];
  wire rd0_n_s = pins_s[1];
  wire rdwr_s = pins_s[0];
  wire bs_n_s = strap_s[1];

  // ----------------------------------------
  // Strap capture after reset release
  // ----------------------------------------
  reg [1:0] rel_cnt;
  reg straps_taken;
  reg [2:0] mode_strap;
  reg status_strap;
  reg big_endian;
  // latch on the fourth clock after release
  // Waits for the synchronisers to carry post-reset levels before capture
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rel_cnt <= 2'h0;
      straps_taken <= 1'b0;
      mode_strap <= 3'h0;
      status_strap <= 1'b0;
      big_endian <= 1'b0;
    end
    else if (!straps_taken)
    begin
      rel_cnt <= rel_cnt + 2'h1;
      if (rel_cnt == 2'h3)
      begin
        straps_taken <= 1'b1;
        mode_strap <= strap_s[4:2];
        status_strap <= strap_s[1];
        big_endian <= strap_s[0];
      end
    end
  end

  wire generic_mode = straps_taken && (mode_strap == `MODE_STRAP_GENERIC) && !status_strap;
  wire byte_strobe_bus_mode = straps_taken && (mode_strap == `MODE_STRAP_STROBE);

  // ----------------------------------------
  // Host clock edge detect
  // ----------------------------------------
  reg bclk_d;
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      bclk_d <= 1'b0;
    else
      bclk_d <= bclk_s;
  end
  wire bclk_rise = bclk_s && !bclk_d;

  // ----------------------------------------
  // Request decode
  // ----------------------------------------
  reg req_rd;
  reg req_wr;
  reg lane_lo;
  reg lane_hi;
  always @*
  begin
    req_rd = 1'b0;
    req_wr = 1'b0;
    lane_lo = 1'b0;
    lane_hi = 1'b0;
    if (generic_mode && !cs_n_s)
    begin
      req_wr = !we0_n_s || !we1_n_s;
      req_rd = !req_wr && (!rd0_n_s || !rdwr_s);
      lane_lo = req_wr ? !we0_n_s : !rd0_n_s;
      lane_hi = req_wr ? !we1_n_s : !rdwr_s;
    end
    else if (byte_strobe_bus_mode && !cs_n_s && !bs_n_s && (!a0_s || !we1_n_s))
    begin
      req_rd = rdwr_s;
      req_wr = !rdwr_s;
      lane_lo = !a0_s;
      lane_hi = !we1_n_s;
    end
  end

  // word address in strobe mode
  // Strobe mode uses bit zero as a lane enable, so the byte address stays even
  wire [15:0] host_addr_in_w = addr_s;
  wire [16:0] byte_addr = {host_addr_in_w, byte_strobe_bus_mode ? 1'b0 : a0_s};
  wire is_reg = byte_addr >= `REG_SPACE_BASE;
  wire [15:0] word_idx = byte_addr[16:1];

  // Endian swap for host view
  function [15:0] swap_bytes;
    input [15:0] val;
    input en;
    begin
      swap_bytes = en ? {val[7:0], val[15:8]} : val;
    end
  endfunction

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  reg [15:0] display_mem [0:DISPLAY_WORDS-1];
  reg [15:0] reg_file [0:REG_WORDS-1];

  // ----------------------------------------
  // Access state machine
  // ----------------------------------------
  reg [2:0] state;
  reg [7:0] arb_cnt;
  reg [7:0] arb_delay;
  reg [15:0] access_cnt;
  reg rd_active;
  reg [15:0] lat_idx;
  reg lat_reg;
  reg lat_lo;
  reg lat_hi;
  reg lat_wr;
  wire [15:0] wdata_host = swap_bytes(wdata_s, big_endian);
  // wait active low
  // Arbitration waits for refresh idle and a minimum delay on each access
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state <= `HS_IDLE;
      wait_n <= 1'b1;
      arb_cnt <= 8'h00;
      rd_active <= 1'b0;
      host_data_out <= 16'h0000;
      access_cnt <= 16'h0000;
      lat_idx <= 16'h0000;
      lat_reg <= 1'b0;
      lat_lo <= 1'b0;
      lat_hi <= 1'b0;
      lat_wr <= 1'b0;
    end
    else
    begin
      case (state)
        `HS_IDLE:
        begin
          if (bclk_rise && (req_rd || req_wr))
          begin
            wait_n <= 1'b0;
            arb_cnt <= 8'h00;
            lat_idx <= is_reg ? {12'h000, word_idx[3:0]} : word_idx;
            lat_reg <= is_reg;
            lat_lo <= lane_lo;
            lat_hi <= lane_hi;
            lat_wr <= req_wr;
            state <= `HS_ARB;
          end
        end
        `HS_ARB:
        begin
          if (arb_cnt != arb_delay)
            arb_cnt <= arb_cnt + 8'h01;
          else if (!refresh_busy)
          begin
            if (!lat_wr)
            begin
              host_data_out <= swap_bytes(lat_reg ? reg_file[lat_idx[3:0]] :
                (lat_idx < DISPLAY_WORDS ? display_mem[lat_idx] : 16'h0000), big_endian);
              rd_active <= 1'b1;
            end
            access_cnt <= access_cnt + 16'h0001;
            state <= `HS_DONE;
          end
        end
        `HS_DONE:
        begin
          wait_n <= 1'b1;
          state <= `HS_RELEASE;
        end
        default:
        begin
          // Hold until the host ends the cycle
          if (!req_rd && !req_wr)
          begin
            rd_active <= 1'b0;
            state <= `HS_IDLE;
          end
        end
      endcase
    end
  end

  // byte lane writes
  // Storage has no reset to stay RAM-like
  always @(posedge ref_clk)
  begin
    if (state == `HS_ARB && arb_cnt == arb_delay && !refresh_busy && lat_wr)
    begin
      if (lat_reg)
      begin
        if (lat_lo)
          reg_file[lat_idx[3:0]][7:0] <= wdata_host[7:0];
        if (lat_hi)
          reg_file[lat_idx[3:0]][15:8] <= wdata_host[15:8];
      end
      else if (lat_idx < DISPLAY_WORDS)
      begin
        if (lat_lo)
          display_mem[lat_idx][7:0] <= wdata_host[7:0];
        if (lat_hi)
          display_mem[lat_idx][15:8] <= wdata_host[15:8];
      end
    end
  end

  assign host_data_oe = rd_active && !cs_n_s;

  // ----------------------------------------
  // APB slave, zero wait
  // ----------------------------------------
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      arb_delay <= `ARB_DELAY_RESET;
    else if (psel && penable && pwrite && paddr[11:0] == `APB_OFS_ARB_DELAY)
      arb_delay <= pwdata[7:0];
  end
  // Read mux, unmapped reads return zero
  always @*
  begin
    if (paddr[11:0] == `APB_OFS_STATUS)
      prdata = {24'h000000, big_endian, byte_strobe_bus_mode, generic_mode, state, !wait_n,
        straps_taken};
    else if (paddr[11:0] == `APB_OFS_ACCESS_CNT)
      prdata = {16'h0000, access_cnt};
    else if (paddr[11:0] == `APB_OFS_ARB_DELAY)
      prdata = {24'h000000, arb_delay};
    else
      prdata = 32'h00000000;
  end

  wire unused_ok = &{1'b0, display_input_clk, paddr[31:12], pwdata[31:8]};
endmodule // lcd_ctrl_host_bus_port
`default_nettype wire

//--- inc/host_port_consts.vh
`ifndef HOST_PORT_CONSTS_VH
`define HOST_PORT_CONSTS_VH
// ----------------------------------------
// Strap decode
// ----------------------------------------
`define MODE_STRAP_GENERIC 3'h7
`define MODE_STRAP_STROBE 3'h3
`define ENDIAN_LITTLE 1'h0
`define ENDIAN_BIG 1'h1
// ----------------------------------------
// Address window, byte addresses
// ----------------------------------------
`define WINDOW_ADDR_W 17
`define REG_SPACE_BASE 17'h1FFE0
`define REG_WORDS 16
`define DISPLAY_WORDS 40960
// ----------------------------------------
// Register bank APB map
// ----------------------------------------
`define APB_OFS_STATUS 12'h000
`define APB_OFS_ACCESS_CNT 12'h004
`define APB_OFS_ARB_DELAY 12'h008
`define ARB_DELAY_RESET 8'h04
// ----------------------------------------
// Host state machine codes
// ----------------------------------------
`define HS_IDLE 3'h0
`define HS_ARB 3'h1
`define HS_DONE 3'h2
`define HS_RELEASE 3'h3
`endif

//--- rtl/sync_two_flop.v
`default_nettype none
// ----------------------------------------
// Two-flop level synchroniser bank
// ----------------------------------------
module sync_two_flop #(
  parameter WIDTH = 1
) (
  input wire ref_clk,
  input wire rst,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      meta <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end
    else
    begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule // sync_two_flop
`default_nettype wire

//--- sim/host_port_asserts.sv
`default_nettype none
module host_port_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic chip_select_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic [15:0] host_data_out,
  input wire logic host_data_oe,
  input wire logic wait_n,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // Register bus never stalls or errors
  a_apb_no_wait: assert property (psel && penable |-> pready)
    else $error("apb stall");
  a_apb_no_error: assert property (psel |-> !pslverr)
    else $error("apb error");
  // Wait spans the arbitration, but not forever
  a_wait_min_len: assert property ($fell(wait_n) |-> !wait_n [*4] ##[1:400] wait_n)
    else $error("wait length");
  a_wait_needs_cs: assert property ($fell(wait_n) |-> !chip_select_n && !$past(chip_select_n, 2))
    else $error("wait without select");
  // Data lines only driven for a selected read
  a_drive_selected: assert property ($rose(host_data_oe) |-> !chip_select_n)
    else $error("drive unselected");
  a_data_first: assert property ($rose(host_data_oe) |-> !wait_n ##[1:3] wait_n)
    else $error("data after wait");
  a_release_after: assert property ($fell(host_data_oe) |-> wait_n)
    else $error("early release");
  a_data_stands: assert property (host_data_oe && $past(host_data_oe) |-> $stable(host_data_out))
    else $error("data moved");
  c_read: cover property ($rose(host_data_oe));
  c_stall: cover property ($fell(wait_n));
  c_apb: cover property (psel && penable);
endmodule // host_port_chk
bind lcd_ctrl_host_bus_port host_port_chk chk (.ref_clk, .rst, .chip_select_n, .psel, .penable,
  .host_data_out, .host_data_oe, .wait_n, .pready, .pslverr);
`default_nettype wire

//--- sim/host_cpu_model.sv
`default_nettype none
module host_cpu_model (
  input wire logic host_bus_clk,
  input wire logic wait_n,
  input wire logic [15:0] host_data_out,
  input wire logic host_data_oe,
  output logic chip_select_n,
  output logic [15:0] host_addr_in,
  output logic addr_bit_zero,
  output logic [15:0] host_data_in,
  output logic low_byte_write_strobe_n,
  output logic high_byte_write_strobe_n,
  output logic low_byte_read_strobe_n,
  output logic read_write_n,
  output logic bus_status_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic strobe_mode = 1'b0;
  logic wen = 1'b0;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] last_v = 16'h0000;
  // Floating bus toggles so a stale value never passes
  assign host_data_in = wen ? wdata : host_data_oe ? host_data_out : ~last_v;
  always @(posedge host_bus_clk)
    last_v <= host_data_in;
  // Release all strobes; address lines drift
  task automatic idle();
    chip_select_n <= 1'b1;
    wen <= 1'b0;
    host_addr_in <= ~host_addr_in;
    {addr_bit_zero, low_byte_write_strobe_n, high_byte_write_strobe_n} <= 3'h7;
    {low_byte_read_strobe_n, read_write_n} <= 2'h3;
    bus_status_n <= strobe_mode;
  endtask
  initial
  begin
    host_addr_in = 16'h0000;
    idle();
  end
  // One transfer, held until wait is seen released
  task automatic xfer(input logic wr, input logic [15:0] w, input logic [1:0] be,
    inout logic [15:0] d);
    @(negedge host_bus_clk);
    chip_select_n <= 1'b0;
    host_addr_in <= w;
    bus_status_n <= 1'b0;
    wen <= wr;
    wdata <= d;
    addr_bit_zero <= strobe_mode ? !be[0] : 1'b0;
    high_byte_write_strobe_n <= strobe_mode ? !be[1] : !(wr && be[1]);
    low_byte_write_strobe_n <= strobe_mode || !(wr && be[0]);
    low_byte_read_strobe_n <= strobe_mode || !(!wr && be[0]);
    read_write_n <= strobe_mode ? !wr : !(!wr && be[1]);
    // low wait sampled on bus clock
    @(posedge host_bus_clk);
    do
      @(posedge host_bus_clk);
    while (!wait_n);
    d = host_data_in;
    idle();
    @(posedge host_bus_clk);
  endtask
endmodule // host_cpu_model
`default_nettype wire

//--- sim/lcd_ctrl_host_bus_port_tb_top.sv
`default_nettype none
module lcd_ctrl_host_bus_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic host_bus_clk = 1'b0;
  logic rst = 1'b1;
  logic refresh_busy = 1'b0;
  logic [3:0] strap = 4'h7;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire pready, pslverr, chip_select_n, addr_bit_zero, host_data_oe, wait_n, bus_status_n;
  wire low_byte_write_strobe_n, high_byte_write_strobe_n, low_byte_read_strobe_n, read_write_n;
  wire [15:0] host_addr_in, host_data_in, host_data_out;
  int err_count = 0;
  int n_tests = 0;
  int acc;
  integer seed = 32'h10EA;
  logic [15:0] w;
  logic [31:0] r;
  logic [15:0] mem [int];
  // Endian strap then mode straps; expected status
  logic [3:0] modes [3] = '{4'h7, 4'h3, 4'hF};
  logic [31:0] stat [3] = '{32'h21, 32'h41, 32'hA1};
  lcd_ctrl_host_bus_port uut (.ref_clk, .rst, .display_input_clk(1'b0), .host_bus_clk,
    .chip_select_n, .host_addr_in, .addr_bit_zero, .host_data_in, .host_data_out,
    .host_data_oe, .low_byte_write_strobe_n, .high_byte_write_strobe_n,
    .low_byte_read_strobe_n, .read_write_n, .bus_status_n, .wait_n,
    .bus_mode_strap_0(strap[0]), .bus_mode_strap_1(strap[1]), .bus_mode_strap_2(strap[2]),
    .endian_select_strap(strap[3]), .refresh_busy, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr);
  host_cpu_model host (.host_bus_clk, .wait_n, .host_data_out, .host_data_oe, .chip_select_n,
    .host_addr_in, .addr_bit_zero, .host_data_in, .low_byte_write_strobe_n,
    .high_byte_write_strobe_n, .low_byte_read_strobe_n, .read_write_n, .bus_status_n);
  // Clocks with unrelated phase
  initial
    forever
      #2 ref_clk = ~ref_clk;
  initial
  begin
    #1.3;
    forever
      #24 host_bus_clk = ~host_bus_clk;
  end
  // Refresh steals memory in random bursts
  initial
    forever
    begin
      repeat (20) @(posedge ref_clk);
      refresh_busy <= 1'($random(seed));
    end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Register bus cycle, read data left in r
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {20'h0, a};
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
      @(posedge ref_clk);
    while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Write lanes, read the word back against the model
  task automatic host_rw(input logic [15:0] a, input logic [1:0] be);
    logic [15:0] d;
    d = 16'($random(seed));
    if (be[0]) mem[a][7:0] = d[7:0];
    if (be[1]) mem[a][15:8] = d[15:8];
    host.xfer(1'b1, a, be, d);
    host.xfer(1'b0, a, 2'h3, d);
    check({16'h0, d}, {16'h0, mem[a]});
    acc += 2;
  endtask
  task automatic restart(input logic [3:0] s);
    strap <= s;
    host.strobe_mode = (s[2:0] == 3'h3);
    host.idle();
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (12) @(posedge ref_clk);
    mem.delete();
    acc = 0;
  endtask
  initial
  begin
    for (int m = 0; m < 3; m++)
    begin
      restart(modes[m]);
      apb(1'b0, 12'h000, 32'h0);
      check(r, stat[m]);
      apb(1'b0, 12'h008, 32'h0);
      check(r, 32'h4);
      apb(1'b1, 12'h008, 32'h3);
      apb(1'b0, 12'h008, 32'h0);
      check(r, 32'h3);
      apb(1'b0, 12'h00C, 32'h0);
      check(r, 32'h0);
      host_rw(16'h0000, 2'h3);
      host_rw(16'hFFF5, 2'h3);
      host_rw(16'h9FFF, 2'h3);
      for (int i = 0; i < 6; i++)
      begin
        w = 16'($unsigned($random(seed)) % 32'hA000);
        host_rw(w, 2'h3);
        host_rw(w, m == 2 ? 2'h3 : 2'(i % 3 + 1));
      end
      apb(1'b0, 12'h004, 32'h0);
      check(r, acc);
      $display("mode %0d done", m);
    end
    complete_run();
  end
  // Cut a hang short
  initial
  begin
    repeat (40000) @(posedge ref_clk);
    err_count++;
    complete_run();
  end
endmodule // lcd_ctrl_host_bus_port_tb_top
`default_nettype wire
